// File: hw/twbc_pkg.sv
// constants and types of the two-wire bus controller
package twbc_pkg;
   // register byte offsets
   localparam logic [4:0] OFF_STATUS = 5'h00;
   localparam logic [4:0] OFF_CONTROL = 5'h04;
   localparam logic [4:0] OFF_CLOCK = 5'h08;
   localparam logic [4:0] OFF_ADDR = 5'h0C;
   localparam logic [4:0] OFF_DATA = 5'h10;
   // control register field positions
   localparam int CTL_BER = 7;
   localparam int CTL_BUS_ERROR_IRQ_ENABLE = 6;
   localparam int CTL_RSTART = 5;
   localparam int CTL_MSEL = 4;
   localparam int CTL_ACK = 3;
   localparam int CTL_GCACK = 2;
   localparam int CTL_INTE = 1;
   localparam int CTL_INT = 0;
   // clock control field positions
   localparam int CLK_FAST = 6;
   localparam int CLK_EN = 5;
   // reset values and fixed bits
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [7:0] CONTROL_RST = 8'h00;
   localparam logic UNUSED_TOP_BIT = 1'b1;
   localparam logic [7:0] GENERAL_CALL = 8'h00;
   // serial clock divider: base clock rate and per-mode m mapping
   localparam int SYS_CLK_KHZ = 16600;
   localparam int PCLK_KHZ = 100000;
   localparam logic [16:0] TICK_STEP = 17'(SYS_CLK_KHZ);
   localparam logic [16:0] TICK_WRAP = 17'(PCLK_KHZ);
   localparam logic [8:0] M_STD_BASE = 9'h041;
   localparam logic [4:0] CS_FAST_LO = 5'h08;
   localparam logic [8:0] M_FAST_SUB = 9'h008;
   localparam logic [8:0] M_FAST_MIN = 9'h009;
   localparam logic [8:0] DIV_OVERHEAD = 9'h002;
   localparam logic [3:0] BITS_DATA = 4'h8;
   localparam logic [3:0] BITS_ALL = 4'h9;

   typedef enum logic [2:0] {
      MS_IDLE, MS_START, MS_LOW, MS_HIGH, MS_STOP_A, MS_STOP_B, MS_RS_A, MS_RS_B
   } twbc_mst_t;

   typedef struct packed {
      logic busy;
      logic repeated_start_flag;
      logic al;
      logic last_ack_bit;
      logic direction_bit;
      logic addressed_flag;
      logic general_call_flag;
      logic first_byte_flag;
   } twbc_status_t;

   typedef struct packed {
      logic bus_error_flag;
      logic bus_error_irq_enable;
      logic master_select;
      logic ack_en;
      logic general_call_ack_enable;
      logic inte;
      logic intf;
   } twbc_ctrl_t;

   typedef struct packed {
      twbc_status_t st;
      twbc_ctrl_t ct;
      logic rs_req;
      logic fast_rate_select;
      logic en;
      logic [4:0] cs;
      logic [6:0] adr;
      logic [7:0] dbuf;
      logic [7:0] shreg;
      logic [3:0] bitcnt;
      twbc_mst_t ms;
      logic [7:0] cnt;
      logic [16:0] acc;
      logic scl_q;
      logic sda_q;
      logic scl_mlow;
      logic sda_low;
      logic scl_oe_n;
      logic sda_oe_n;
      logic scl_out;
      logic sda_out;
      logic irq;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } twbc_state_t;
endpackage

// File: hw/twbc_top.sv
// two-wire bus controller, master and slave, APB register slave
//
// Chosen here: the APB slave port.
`timescale 1ns/100ps
module twbc_top #(
   parameter int PADDR_W = 8
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [PADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // two-wire pins, enable low pulls the wire low
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe_n,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   // interrupt request
   output logic irq
);
   twbc_pkg::twbc_state_t r;
   twbc_pkg::twbc_state_t n;
   logic rise, fall, start_c, stop_c, tick, setup, wr, hit, ack, lost;
   logic [8:0] m, period, half_lo, half_hi;
   logic [31:0] rdata;
   logic [4:0] off;

   if (PADDR_W < 5)
   begin : g_chk
      $error("PADDR_W must be at least 5");
   end

   always_comb
   begin
      n = r;
      n.scl_q = scl_in;
      n.sda_q = sda_in;
      rise = !r.scl_q && scl_in;
      fall = r.scl_q && !scl_in;
      start_c = r.scl_q && scl_in && r.sda_q && !sda_in;
      stop_c = r.scl_q && scl_in && !r.sda_q && sda_in;
      lost = 1'b0;
      ack = 1'b0;
      // fractional tick at the base clock rate
      if (r.acc + twbc_pkg::TICK_STEP >= twbc_pkg::TICK_WRAP)
      begin
         tick = 1'b1;
         n.acc = r.acc + twbc_pkg::TICK_STEP - twbc_pkg::TICK_WRAP;
      end
      else
      begin
         tick = 1'b0;
         n.acc = r.acc + twbc_pkg::TICK_STEP;
      end
      if (r.fast_rate_select)
      begin
         m = (r.cs < twbc_pkg::CS_FAST_LO) ? twbc_pkg::M_FAST_MIN
            : {4'h0, r.cs} - twbc_pkg::M_FAST_SUB + twbc_pkg::M_FAST_MIN;
         period = 9'((10'(m) * 10'h003) >> 1) + twbc_pkg::DIV_OVERHEAD;
      end
      else
      begin
         m = twbc_pkg::M_STD_BASE + {4'h0, r.cs};
         period = {m[7:0], 1'b0} + twbc_pkg::DIV_OVERHEAD;
      end
      half_lo = period >> 1;
      half_hi = period - half_lo;
      if (tick && r.cnt != 8'h00)
      begin
         n.cnt = r.cnt - 8'h01;
      end
      // apb: answer in the access cycle, no wait states
      off = paddr[4:0];
      hit = ((paddr >> 5) == '0) && (off == twbc_pkg::OFF_STATUS || off == twbc_pkg::OFF_CONTROL
         || off == twbc_pkg::OFF_CLOCK || off == twbc_pkg::OFF_ADDR || off == twbc_pkg::OFF_DATA);
      setup = psel && !penable;
      wr = psel && penable && r.pready && pwrite && !r.pslverr;
      rdata = 32'h0000_0000;
      if ((paddr >> 5) == '0)
      begin
         unique case (off)
            twbc_pkg::OFF_STATUS: rdata = 32'(r.st);
            twbc_pkg::OFF_CONTROL: rdata = {24'h00_0000, r.ct.bus_error_flag, r.ct.bus_error_irq_enable, 1'b0, r.ct.master_select,
               r.ct.ack_en, r.ct.general_call_ack_enable, r.ct.inte, r.ct.intf};
            twbc_pkg::OFF_CLOCK: rdata = {24'h00_0000, twbc_pkg::UNUSED_TOP_BIT, r.fast_rate_select, r.en,
               r.cs};
            twbc_pkg::OFF_ADDR: rdata = {24'h00_0000, twbc_pkg::UNUSED_TOP_BIT, r.adr};
            twbc_pkg::OFF_DATA: rdata = {24'h00_0000, r.shreg};
            default: rdata = 32'h0000_0000;
         endcase
      end
      n.pready = setup;
      n.pslverr = setup && !hit;
      if (setup)
      begin
         n.prdata = rdata;
      end
      // register writes first, so hardware events below win over clears
      if (wr)
      begin
         unique case (off)
            twbc_pkg::OFF_CONTROL:
            begin
               if (!pwdata[twbc_pkg::CTL_BER])
               begin
                  n.ct.bus_error_flag = 1'b0;
               end
               n.ct.bus_error_irq_enable = pwdata[twbc_pkg::CTL_BUS_ERROR_IRQ_ENABLE];
               n.ct.ack_en = pwdata[twbc_pkg::CTL_ACK];
               n.ct.general_call_ack_enable = pwdata[twbc_pkg::CTL_GCACK];
               n.ct.inte = pwdata[twbc_pkg::CTL_INTE];
               if (!pwdata[twbc_pkg::CTL_INT] && r.ct.intf)
               begin
                  n.ct.intf = 1'b0;
                  n.st.al = 1'b0;
                  n.st.repeated_start_flag = 1'b0;
                  n.st.first_byte_flag = 1'b0;
                  if (r.st.direction_bit)
                  begin
                     n.shreg = r.dbuf;
                     n.sda_low = !r.dbuf[7];
                  end
                  else
                  begin
                     n.sda_low = 1'b0;
                  end
               end
               if (pwdata[twbc_pkg::CTL_RSTART] && r.ct.master_select && r.st.busy)
               begin
                  n.rs_req = 1'b1;
               end
               if (pwdata[twbc_pkg::CTL_MSEL] && !r.ct.master_select)
               begin
                  if (r.st.busy)
                  begin
                     n.st.al = 1'b1;
                     n.ct.intf = 1'b1;
                  end
                  else
                  begin
                     n.ct.master_select = 1'b1;
                     n.ms = twbc_pkg::MS_START;
                     n.shreg = r.dbuf;
                     n.sda_low = 1'b1;
                     n.cnt = half_hi[7:0];
                  end
               end
               else if (!pwdata[twbc_pkg::CTL_MSEL])
               begin
                  n.ct.master_select = 1'b0;
               end
            end
            twbc_pkg::OFF_CLOCK:
            begin
               n.fast_rate_select = pwdata[twbc_pkg::CLK_FAST];
               n.en = pwdata[twbc_pkg::CLK_EN];
               n.cs = pwdata[4:0];
            end
            twbc_pkg::OFF_ADDR: n.adr = pwdata[6:0];
            twbc_pkg::OFF_DATA:
            begin
               n.dbuf = pwdata[7:0];
               if (!r.st.busy)
               begin
                  n.shreg = pwdata[7:0];
               end
            end
            default:
            begin
            end
         endcase
      end
      // master clock and condition generator
      if (r.en)
      begin
         unique case (r.ms)
            twbc_pkg::MS_IDLE: n.scl_mlow = 1'b0;
            twbc_pkg::MS_START:
            begin
               if (r.cnt == 8'h00)
               begin
                  n.scl_mlow = 1'b1;
                  n.cnt = half_lo[7:0];
                  n.ms = twbc_pkg::MS_LOW;
               end
            end
            twbc_pkg::MS_LOW:
            begin
               if (r.cnt == 8'h00 && r.bitcnt == 4'h0 && !n.ct.master_select)
               begin
                  n.sda_low = 1'b1;
                  n.ct.intf = 1'b0;
                  n.rs_req = 1'b0;
                  n.cnt = half_lo[7:0];
                  n.ms = twbc_pkg::MS_STOP_A;
               end
               else if (r.cnt == 8'h00 && r.bitcnt == 4'h0 && n.rs_req)
               begin
                  n.sda_low = 1'b0;
                  n.ct.intf = 1'b0;
                  n.rs_req = 1'b0;
                  n.cnt = half_lo[7:0];
                  n.ms = twbc_pkg::MS_RS_A;
               end
               else if (r.cnt == 8'h00 && !n.ct.intf)
               begin
                  n.scl_mlow = 1'b0;
                  n.cnt = half_hi[7:0];
                  n.ms = twbc_pkg::MS_HIGH;
               end
            end
            twbc_pkg::MS_HIGH, twbc_pkg::MS_STOP_B, twbc_pkg::MS_RS_B:
            begin
               if (!scl_in)
               begin
                  n.cnt = half_hi[7:0];
               end
               else if (r.cnt == 8'h00)
               begin
                  n.cnt = half_lo[7:0];
                  if (r.ms == twbc_pkg::MS_HIGH)
                  begin
                     n.scl_mlow = 1'b1;
                     n.ms = twbc_pkg::MS_LOW;
                  end
                  else if (r.ms == twbc_pkg::MS_STOP_B)
                  begin
                     n.sda_low = 1'b0;
                     n.ms = twbc_pkg::MS_IDLE;
                  end
                  else
                  begin
                     n.sda_low = 1'b1;
                     n.shreg = n.dbuf;
                     n.cnt = half_hi[7:0];
                     n.ms = twbc_pkg::MS_START;
                  end
               end
            end
            twbc_pkg::MS_STOP_A, twbc_pkg::MS_RS_A:
            begin
               if (r.cnt == 8'h00)
               begin
                  n.scl_mlow = 1'b0;
                  n.cnt = half_hi[7:0];
                  n.ms = (r.ms == twbc_pkg::MS_STOP_A) ? twbc_pkg::MS_STOP_B : twbc_pkg::MS_RS_B;
               end
            end
         endcase
      end
      // bus monitor and bit engine, shared by master and slave
      if (r.en)
      begin
         if (start_c || stop_c)
         begin
            // conditions in the first pulse after a byte are legal stop or restart
            if (r.st.busy && r.bitcnt > 4'h1)
            begin
               n.ct.bus_error_flag = 1'b1;
               n.en = 1'b0;
            end
            n.st.busy = start_c;
            n.st.repeated_start_flag = start_c && r.st.busy;
            n.st.last_ack_bit = 1'b0;
            n.st.addressed_flag = 1'b0;
            n.st.general_call_flag = 1'b0;
            n.st.direction_bit = start_c && r.ct.master_select;
            n.bitcnt = 4'h0;
            if (start_c)
            begin
               n.st.first_byte_flag = 1'b1;
            end
            if (r.ct.master_select)
            begin
               n.ct.intf = 1'b0;
            end
         end
         else if (rise && r.st.busy)
         begin
            if (r.bitcnt < twbc_pkg::BITS_DATA)
            begin
               n.shreg = {r.shreg[6:0], sda_in};
               lost = r.ct.master_select && r.st.direction_bit && !r.sda_low && !sda_in;
            end
            else
            begin
               n.st.last_ack_bit = sda_in;
            end
            n.bitcnt = r.bitcnt + 4'h1;
         end
         else if (fall && r.st.busy)
         begin
            if (r.bitcnt < twbc_pkg::BITS_DATA)
            begin
               n.sda_low = r.st.direction_bit && !r.shreg[7];
            end
            else if (r.bitcnt == twbc_pkg::BITS_DATA)
            begin
               if (r.st.first_byte_flag && !r.ct.master_select)
               begin
                  if (r.shreg[7:1] == r.adr)
                  begin
                     n.st.addressed_flag = 1'b1;
                     n.st.direction_bit = r.shreg[0];
                     ack = 1'b1;
                  end
                  else if (r.shreg == twbc_pkg::GENERAL_CALL)
                  begin
                     n.st.general_call_flag = 1'b1;
                     ack = r.ct.general_call_ack_enable;
                  end
                  else
                  begin
                     n.st.repeated_start_flag = 1'b0;
                     n.st.first_byte_flag = 1'b0;
                  end
               end
               else if (!r.st.direction_bit && (r.ct.master_select || r.st.addressed_flag || r.st.general_call_flag))
               begin
                  ack = r.ct.ack_en;
               end
               n.sda_low = ack;
            end
            else
            begin
               n.bitcnt = 4'h0;
               n.sda_low = 1'b0;
               if (r.ct.master_select || r.st.addressed_flag || r.st.general_call_flag)
               begin
                  n.ct.intf = 1'b1;
                  n.scl_mlow = r.ct.master_select;
               end
               if (r.ct.master_select && r.st.first_byte_flag)
               begin
                  n.st.direction_bit = !r.shreg[0];
               end
            end
         end
         if (lost)
         begin
            n.st.al = 1'b1;
            n.ct.master_select = 1'b0;
            n.sda_low = 1'b0;
            n.scl_mlow = 1'b0;
            n.ms = twbc_pkg::MS_IDLE;
         end
      end
      if (!n.en)
      begin
         n.st = twbc_pkg::STATUS_RST;
         n.ct.master_select = 1'b0;
         n.ct.ack_en = 1'b0;
         n.ct.general_call_ack_enable = 1'b0;
         n.ct.inte = 1'b0;
         n.ct.intf = 1'b0;
         n.rs_req = 1'b0;
         n.ms = twbc_pkg::MS_IDLE;
         n.bitcnt = 4'h0;
         n.sda_low = 1'b0;
         n.scl_mlow = 1'b0;
      end
      n.scl_oe_n = !(n.scl_mlow || n.ct.intf);
      n.sda_oe_n = !n.sda_low;
      n.irq = (n.ct.bus_error_flag && n.ct.bus_error_irq_enable) || (n.ct.intf && n.ct.inte);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         r <= '0;
         r.scl_oe_n <= 1'b1;
         r.sda_oe_n <= 1'b1;
         r.scl_q <= 1'b1;
         r.sda_q <= 1'b1;
      end
      else
      begin
         r <= n;
      end
   end

   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign scl_out = r.scl_out;
   assign scl_oe_n = r.scl_oe_n;
   assign sda_out = r.sda_out;
   assign sda_oe_n = r.sda_oe_n;
   assign irq = r.irq;
endmodule

// File: tb/twbc_far_slave.sv
// behavioural slave on the far side of the two-wire bus
`timescale 1ns/100ps
module twbc_far_slave (
   // wire levels
   input wire logic scl,
   input wire logic sda,
   // scenario controls
   input wire logic nack,
   input wire logic hold_low,
   // own pull-down and observed traffic
   output logic sda_rel,
   output logic [7:0] rx_byte,
   output int n_rx
);
   logic [7:0] sh;
   logic ack_dr;
   int bc;
   assign sda_rel = !ack_dr && !hold_low;
   initial
   begin
      ack_dr = 1'b0;
      rx_byte = 8'h00;
      n_rx = 0;
      sh = 8'h00;
      bc = 0;
   end
   // start or stop restarts the byte
   always @(sda) if (scl === 1'b1) bc = 0;
   always @(posedge scl) if (bc < 8)
   begin
      sh = {sh[6:0], sda};
      bc++;
   end
   always @(negedge scl)
   begin
      if (bc == 8)
      begin
         rx_byte = sh;
         n_rx++;
         ack_dr = !nack;
         bc = 9;
      end
      else if (bc == 9)
      begin
         ack_dr = 1'b0;
         bc = 0;
      end
   end
endmodule

// File: tb/twbc_properties.sv
// port assertions for the two-wire bus controller
`timescale 1ns/100ps
module twbc_properties #(
   parameter int PADDR_W = 8
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [PADDR_W-1:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // two-wire pins and request
   input wire logic scl_out,
   input wire logic scl_oe_n,
   input wire logic sda_out,
   input wire logic sda_oe_n,
   input wire logic irq
);
   logic [7:0] hi_cnt;
   logic rd;
   assign rd = pready && !pwrite && !pslverr;
   // cycles since the clock line was released
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn) hi_cnt <= 8'h00;
      else if (!scl_oe_n) hi_cnt <= 8'h00;
      else if (hi_cnt != 8'hFF) hi_cnt <= hi_cnt + 8'h01;
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_pready_pulse;
      psel && !penable |=> pready ##1 !pready;
   endproperty
   a_pready_pulse: assert property (p_pready_pulse)
      else $error("pready is not a one cycle answer");
   property p_unmapped;
      pready && paddr > 8'h10 |-> pslverr && prdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped access not refused");
   property p_top_one;
      rd && (paddr[4:0] == twbc_pkg::OFF_CLOCK || paddr[4:0] == twbc_pkg::OFF_ADDR)
         |-> prdata[7] && prdata[31:8] == 24'h0;
   endproperty
   a_top_one: assert property (p_top_one)
      else $error("unused top bit not read as one");
   property p_irq_gate;
      rd && paddr[4:0] == twbc_pkg::OFF_CONTROL && !prdata[twbc_pkg::CTL_INTE]
         && !prdata[twbc_pkg::CTL_BUS_ERROR_IRQ_ENABLE] |=> !irq;
   endproperty
   a_irq_gate: assert property (p_irq_gate)
      else $error("irq high with both enables off");
   property p_int_hold;
      rd && paddr[4:0] == twbc_pkg::OFF_CONTROL && prdata[twbc_pkg::CTL_INT] |=> !scl_oe_n;
   endproperty
   a_int_hold: assert property (p_int_hold)
      else $error("clock not held low at transfer end");
   property p_dis_release;
      rd && paddr[4:0] == twbc_pkg::OFF_CLOCK && !prdata[twbc_pkg::CLK_EN]
         |=> scl_oe_n && sda_oe_n;
   endproperty
   a_dis_release: assert property (p_dis_release)
      else $error("lines pulled while disabled");
   property p_scl_high;
      $fell(scl_oe_n) |-> hi_cnt >= 8'h28;
   endproperty
   a_scl_high: assert property (p_scl_high)
      else $error("serial clock high phase too short");
   property p_open_drain;
      !scl_out && !sda_out;
   endproperty
   a_open_drain: assert property (p_open_drain)
      else $error("pin output level not low");
endmodule

bind twbc_top twbc_properties #(.PADDR_W(PADDR_W)) props_u (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
   .irq(irq)
);

// File: tb/twbc_tb_top.sv
// self-checking bench for the two-wire bus controller
`timescale 1ns/100ps
module twbc_tb_top;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic scl_out, scl_oe_n, sda_out, sda_oe_n, irq, er;
   logic nack, hold_low, sda_rel;
   logic [7:0] rx_byte;
   int n_rx, error_cnt, n_tests;
   // pull-ups on both wires
   wire logic scl_w = scl_oe_n ? 1'b1 : scl_out;
   wire logic sda_w = (sda_oe_n ? 1'b1 : sda_out) & sda_rel;
   twbc_top #(.PADDR_W(8)) dut_u (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .scl_in(scl_w), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_w),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n), .irq(irq)
   );
   twbc_far_slave far_u (.scl(scl_w), .sda(sda_w), .nack(nack), .hold_low(hold_low),
      .sda_rel(sda_rel), .rx_byte(rx_byte), .n_rx(n_rx));
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic bound(input logic ok);
      if (!ok)
      begin
         error_cnt++;
         $display("unexpected wait expected done seen timeout");
         give_verdict();
      end
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic xfer(input logic [4:0] a, input logic w, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= {3'h0, a};
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'b1 && k < 50);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      bound(pready === 1'b1);
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      xfer(a, 1'b1, {24'h0, d});
   endtask
   task automatic rchk(input string nm, input logic [4:0] a, input logic [7:0] e);
      xfer(a, 1'b0, 32'h0);
      chk(nm, {24'h0, e}, rd);
   endtask
   task automatic smask(input logic [7:0] m, input logic [7:0] e);
      xfer(twbc_pkg::OFF_STATUS, 1'b0, 32'h0);
      chk("bus_status", {24'h0, e}, rd & {24'h0, m});
   endtask
   task automatic wait_irq(input logic lvl);
      int k;
      k = 0;
      while (irq !== lvl && k < 8000)
      begin
         @(posedge pclk);
         k++;
      end
      bound(irq === lvl);
   endtask
   task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
      n_tests++;
      if (g < lo || g > hi)
      begin
         error_cnt++;
         $display("unexpected %s expected %0d to %0d seen %0d", nm, lo, hi, g);
      end
   endtask
   // cycles of the first serial clock high phase after the next low
   task automatic scl_high(output int c);
      int k;
      k = 0;
      c = 0;
      while (scl_w !== 1'b0 && k < 4000)
      begin
         @(posedge pclk);
         k++;
      end
      while (scl_w !== 1'b1 && k < 4000)
      begin
         @(posedge pclk);
         k++;
      end
      while (scl_w === 1'b1 && k < 4000)
      begin
         @(posedge pclk);
         k++;
         c++;
      end
      bound(k < 4000);
   endtask
   task automatic wait_idle;
      int k;
      k = 0;
      do
      begin
         xfer(twbc_pkg::OFF_STATUS, 1'b0, 32'h0);
         k++;
      end
      while (rd[7] !== 1'b0 && k < 2000);
      bound(rd[7] === 1'b0);
   endtask
   task automatic t_reset;
      rchk("bus_status", twbc_pkg::OFF_STATUS, twbc_pkg::STATUS_RST);
      rchk("bus_control", twbc_pkg::OFF_CONTROL, twbc_pkg::CONTROL_RST);
      rchk("clock_control", twbc_pkg::OFF_CLOCK, 8'h80);
      rchk("own_slave_address", twbc_pkg::OFF_ADDR, 8'h80);
      xfer(5'h14, 1'b0, 32'h0);
      chk("unmapped_err", 32'h1, {31'h0, er});
      wr(twbc_pkg::OFF_ADDR, 8'h52);
      rchk("own_slave_address", twbc_pkg::OFF_ADDR, 8'hD2);
      wr(twbc_pkg::OFF_CONTROL, 8'h5E);
      rchk("bus_control", twbc_pkg::OFF_CONTROL, 8'h40);
      wr(twbc_pkg::OFF_CONTROL, 8'h00);
   endtask
   task automatic t_master;
      int hc;
      int nom;
      // code 1F fast: m is 32, high half of the period in pclk cycles
      nom = (32 * 3 / 2 + 2 - (32 * 3 / 2 + 2) / 2) * twbc_pkg::PCLK_KHZ
         / twbc_pkg::SYS_CLK_KHZ;
      wr(twbc_pkg::OFF_CLOCK, 8'h7F);
      rchk("clock_control", twbc_pkg::OFF_CLOCK, 8'hFF);
      wr(twbc_pkg::OFF_DATA, 8'hA4);
      wr(twbc_pkg::OFF_CONTROL, 8'h12);
      scl_high(hc);
      chk_rng("scl_high_cycles", nom - 8, nom + 8, hc);
      wait_irq(1'b1);
      chk("far_byte", 32'hA4, {24'h0, rx_byte});
      chk("scl_wire", 32'h0, {31'h0, scl_w});
      smask(8'hB8, 8'h88);
      nack <= 1'b1;
      wr(twbc_pkg::OFF_DATA, 8'h3C);
      wr(twbc_pkg::OFF_CONTROL, 8'h32);
      wait_irq(1'b0);
      wait_irq(1'b1);
      chk("far_byte", 32'h3C, {24'h0, rx_byte});
      smask(8'h50, 8'h50);
      wr(twbc_pkg::OFF_CONTROL, 8'h11);
      wait_irq(1'b0);
      rchk("bus_control", twbc_pkg::OFF_CONTROL, 8'h11);
      wr(twbc_pkg::OFF_CONTROL, 8'h02);
      wait_idle();
      rchk("bus_control", twbc_pkg::OFF_CONTROL, 8'h02);
      chk("far_count", 32'h2, 32'(n_rx));
   endtask
   task automatic t_arb;
      nack <= 1'b0;
      hold_low <= 1'b1;
      smask(8'h80, 8'h80);
      wr(twbc_pkg::OFF_CONTROL, 8'h12);
      wait_irq(1'b1);
      smask(8'h20, 8'h20);
      rchk("bus_control", twbc_pkg::OFF_CONTROL, 8'h03);
      wr(twbc_pkg::OFF_CONTROL, 8'h00);
      smask(8'h20, 8'h00);
      hold_low <= 1'b0;
      wait_idle();
      chk("far_count", 32'h2, 32'(n_rx));
   endtask
   task automatic t_disable;
      wr(twbc_pkg::OFF_CLOCK, 8'h00);
      rchk("clock_control", twbc_pkg::OFF_CLOCK, 8'h80);
      rchk("bus_status", twbc_pkg::OFF_STATUS, 8'h00);
   endtask
   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      nack = 1'b0;
      hold_low = 1'b0;
      error_cnt = 0;
      n_tests = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_master();
      t_arb();
      t_disable();
      give_verdict();
   end
endmodule
